// ### src/prk_pkg.sv
// Purpose: shared constants for the rail and power key control block
// Assumes: 10 MHz system clock, byte-wide register port
// Notes: times are in milliseconds, counted on a 1 ms tick
package prk_pkg;
    // register offsets
    localparam logic [7:0] PRK_KEY_STATUS_ADDR = 8'h00;
    localparam logic [7:0] PRK_BUTTON_TIMING_ADDR = 8'h02;
    localparam logic [7:0] PRK_FAULT_STATUS_ADDR = 8'h03;
    localparam logic [7:0] PRK_MISC_COMMAND_ADDR = 8'h04;
    localparam logic [7:0] PRK_RAIL_ENABLE_ADDR = 8'h05;
    localparam logic [7:0] PRK_DISCHARGE_ADDR = 8'h06;
    localparam logic [7:0] PRK_IDENTITY_ADDR = 8'h20;

    // field positions
    localparam int PRK_RESTART_BIT = 7;
    localparam int PRK_HOLD_OFF_EN_BIT = 6;
    localparam int PRK_DEBOUNCE_LSB = 4;
    localparam int PRK_LONG_HOLD_LSB = 2;
    localparam int PRK_HOLD_OFF_LSB = 0;
    localparam int PRK_FAULT_CLEAR_BIT = 3;
    localparam int PRK_HOLD_OFF_FLAG_BIT = 6;
    localparam int PRK_LONG_HOLD_FLAG_BIT = 4;
    localparam int PRK_KEY_PRESS_FLAG_BIT = 3;
    localparam int PRK_PART_CODE_LSB = 3;
    localparam int PRK_NUM_BUCKS = 6;

    // reset values
    localparam logic [7:0] PRK_BUTTON_TIMING_RST = 8'hC7;
    localparam logic [7:0] PRK_RAIL_ENABLE_RST = 8'hFF;
    localparam logic [7:0] PRK_DISCHARGE_RST = 8'h00;

    // timebase
    localparam int PRK_CLK_PERIOD_NS = 100;
    localparam int PRK_NS_PER_MS = 1000000;
    localparam int PRK_TICK_CYC = PRK_NS_PER_MS / PRK_CLK_PERIOD_NS;

    // button times in ms
    localparam int PRK_DEBOUNCE_MS_0 = 128;
    localparam int PRK_DEBOUNCE_MS_1 = 500;
    localparam int PRK_DEBOUNCE_MS_2 = 1000;
    localparam int PRK_DEBOUNCE_MS_3 = 1500;
    localparam int PRK_LONG_HOLD_MS_0 = 1000;
    localparam int PRK_LONG_HOLD_MS_1 = 2000;
    localparam int PRK_LONG_HOLD_MS_2 = 3000;
    localparam int PRK_LONG_HOLD_MS_3 = 4000;
    localparam int PRK_HOLD_OFF_MS_0 = 6000;
    localparam int PRK_HOLD_OFF_MS_1 = 7000;
    localparam int PRK_HOLD_OFF_MS_2 = 8000;
    localparam int PRK_HOLD_OFF_MS_3 = 10000;
    localparam int PRK_RESTART_MS = 1000;
    localparam int PRK_POWER_DOWN_MS = 64;
    localparam int PRK_MS_W = 14;

    typedef enum logic [3:0] {
        PRK_ST_OFF = 4'b0001,
        PRK_ST_ON = 4'b0010,
        PRK_ST_DOWN = 4'b0100,
        PRK_ST_WAIT = 4'b1000
    } prk_state_t;
endpackage

// ### src/prk_sync.sv
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs change slowly relative to sys_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module prk_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ### src/prk_tick.sv
// Purpose: fixed-rate tick generator for the millisecond timebase
// Assumes: CYCLES of at least 1
// Notes: tick is a one-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
module prk_tick #(
    parameter int CYCLES = 10000
) (
    input wire logic sys_clk,
    input wire logic rstn,
    output logic tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule

// ### src/prk_ctrl.sv
// Purpose: rail enable, discharge, fault flags and power button timing
// Assumes: byte register port from the serial front end, button pin active low
// Notes: all hold times are counted on a 1 ms internal tick
`timescale 1ns/1ps
module prk_ctrl
    import prk_pkg::*;
#(
    parameter int TICK_CYCLES = PRK_TICK_CYC,
    parameter logic [4:0] PART_CODE = 5'h0A, // arbitrary value
    parameter logic [2:0] REVISION = 3'h1 // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_button_n,
    input wire logic [7:0] rail_uvp,
    output logic [7:0] rail_run,
    output logic [7:0] rail_discharge,
    output logic power_up
);
    localparam logic [PRK_MS_W-1:0] MS_MAX = '1;

    logic tick;
    logic button_n_s;
    logic button_n_d_r;
    logic [7:0] uvp_s;
    logic pressed;
    logic press_edge;
    logic [PRK_MS_W-1:0] hold_ms_r;
    logic [PRK_MS_W-1:0] phase_ms_r;
    logic [PRK_MS_W-1:0] debounce_ms;
    logic [PRK_MS_W-1:0] long_hold_ms;
    logic [PRK_MS_W-1:0] hold_off_ms;
    logic debounce_hit;
    logic long_hold_hit;
    logic hold_off_hit;
    logic [7:0] timing_r;
    logic [7:0] enable_r;
    logic [7:0] discharge_en_r;
    logic [7:0] fault_r;
    logic key_press_flag_r;
    logic long_hold_flag_r;
    logic hold_off_flag_r;
    logic restart_pending_r;
    prk_state_t state_r;
    prk_state_t state_nxt;
    logic wr_timing;
    logic wr_enable;
    logic wr_discharge;
    logic wr_misc;
    logic rd_key_status;
    logic fault_clear;
    logic [7:0] rd_mux;

    prk_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(tick)
    );

    prk_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_button_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(power_button_n),
        .sync_out(button_n_s)
    );

    prk_sync #(
        .WIDTH(8),
        .RST_VAL(8'h00)
    ) u_uvp_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(rail_uvp),
        .sync_out(uvp_s)
    );

    // register port decode
    assign wr_timing = reg_wr && (reg_addr == PRK_BUTTON_TIMING_ADDR);
    assign wr_enable = reg_wr && (reg_addr == PRK_RAIL_ENABLE_ADDR);
    assign wr_discharge = reg_wr && (reg_addr == PRK_DISCHARGE_ADDR);
    assign wr_misc = reg_wr && (reg_addr == PRK_MISC_COMMAND_ADDR);
    assign rd_key_status = reg_rd && (reg_addr == PRK_KEY_STATUS_ADDR);
    assign fault_clear = wr_misc && reg_wdata[PRK_FAULT_CLEAR_BIT];

    // button edge and hold measurement
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            button_n_d_r <= 1'b1;
        end else begin
            button_n_d_r <= button_n_s;
        end
    end

    assign pressed = !button_n_s;
    assign press_edge = button_n_d_r && !button_n_s;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_ms_r <= '0;
        end else if (!pressed) begin
            hold_ms_r <= '0;
        end else if (tick && hold_ms_r != MS_MAX) begin
            hold_ms_r <= hold_ms_r + 1'b1;
        end
    end

    // threshold selection
    always_comb begin
        case (timing_r[PRK_DEBOUNCE_LSB +: 2])
            2'h0: debounce_ms = PRK_MS_W'(PRK_DEBOUNCE_MS_0);
            2'h1: debounce_ms = PRK_MS_W'(PRK_DEBOUNCE_MS_1);
            2'h2: debounce_ms = PRK_MS_W'(PRK_DEBOUNCE_MS_2);
            default: debounce_ms = PRK_MS_W'(PRK_DEBOUNCE_MS_3);
        endcase
        case (timing_r[PRK_LONG_HOLD_LSB +: 2])
            2'h0: long_hold_ms = PRK_MS_W'(PRK_LONG_HOLD_MS_0);
            2'h1: long_hold_ms = PRK_MS_W'(PRK_LONG_HOLD_MS_1);
            2'h2: long_hold_ms = PRK_MS_W'(PRK_LONG_HOLD_MS_2);
            default: long_hold_ms = PRK_MS_W'(PRK_LONG_HOLD_MS_3);
        endcase
        case (timing_r[PRK_HOLD_OFF_LSB +: 2])
            2'h0: hold_off_ms = PRK_MS_W'(PRK_HOLD_OFF_MS_0);
            2'h1: hold_off_ms = PRK_MS_W'(PRK_HOLD_OFF_MS_1);
            2'h2: hold_off_ms = PRK_MS_W'(PRK_HOLD_OFF_MS_2);
            default: hold_off_ms = PRK_MS_W'(PRK_HOLD_OFF_MS_3);
        endcase
    end

    // one pulse as the held time passes each limit
    assign debounce_hit = pressed && tick && (hold_ms_r == debounce_ms);
    assign long_hold_hit = pressed && tick && (hold_ms_r == long_hold_ms);
    assign hold_off_hit = pressed && tick && (hold_ms_r == hold_off_ms)
        && timing_r[PRK_HOLD_OFF_EN_BIT];

    // writable control registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timing_r <= PRK_BUTTON_TIMING_RST;
        end else if (wr_timing) begin
            timing_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable_r <= PRK_RAIL_ENABLE_RST;
        end else if (wr_enable) begin
            enable_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            discharge_en_r <= PRK_DISCHARGE_RST;
        end else if (wr_discharge) begin
            discharge_en_r <= reg_wdata;
        end
    end

    // sticky fault flags, a new fault wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fault
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    fault_r[gi] <= 1'b0;
                end else if (uvp_s[gi]) begin
                    fault_r[gi] <= 1'b1;
                end else if (fault_clear) begin
                    fault_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // button flags, set wins over read or new press
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            key_press_flag_r <= 1'b0;
        end else if (debounce_hit) begin
            key_press_flag_r <= 1'b1;
        end else if (rd_key_status || press_edge) begin
            key_press_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            long_hold_flag_r <= 1'b0;
        end else if (long_hold_hit) begin
            long_hold_flag_r <= 1'b1;
        end else if (rd_key_status || press_edge) begin
            long_hold_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_off_flag_r <= 1'b0;
        end else if (hold_off_hit && state_r == PRK_ST_ON) begin
            hold_off_flag_r <= 1'b1;
        end else if (rd_key_status || press_edge) begin
            hold_off_flag_r <= 1'b0;
        end
    end

    // power state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PRK_ST_OFF: begin
                if (debounce_hit) begin
                    state_nxt = PRK_ST_ON;
                end
            end
            PRK_ST_ON: begin
                if (hold_off_hit) begin
                    state_nxt = PRK_ST_DOWN;
                end
            end
            PRK_ST_DOWN: begin
                if (tick && phase_ms_r == PRK_MS_W'(PRK_POWER_DOWN_MS - 1)) begin
                    state_nxt = restart_pending_r ? PRK_ST_WAIT : PRK_ST_OFF;
                end
            end
            PRK_ST_WAIT: begin
                if (tick && phase_ms_r == PRK_MS_W'(PRK_RESTART_MS - 1)) begin
                    state_nxt = PRK_ST_ON;
                end
            end
            default: state_nxt = PRK_ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= PRK_ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // time spent in the power-down and restart phases
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_ms_r <= '0;
        end else if (state_nxt != state_r) begin
            phase_ms_r <= '0;
        end else if (tick) begin
            phase_ms_r <= phase_ms_r + 1'b1;
        end
    end

    // restart choice latched when the hold-off shutdown begins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            restart_pending_r <= 1'b0;
        end else if (state_r == PRK_ST_ON && hold_off_hit) begin
            restart_pending_r <= timing_r[PRK_RESTART_BIT];
        end
    end

    // rail drive
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rail_run <= 8'h00;
            rail_discharge <= 8'h00;
            power_up <= 1'b0;
        end else begin
            power_up <= (state_r == PRK_ST_ON);
            rail_run <= (state_r == PRK_ST_ON) ? enable_r : 8'h00;
            if (state_r == PRK_ST_ON) begin
                rail_discharge <= 8'h00;
            end else if (state_r == PRK_ST_DOWN) begin
                rail_discharge <= discharge_en_r
                    | {{(8 - PRK_NUM_BUCKS){1'b0}}, {PRK_NUM_BUCKS{1'b1}}};
            end else begin
                rail_discharge <= discharge_en_r;
            end
        end
    end

    // read data
    always_comb begin
        case (reg_addr)
            PRK_KEY_STATUS_ADDR: begin
                rd_mux = 8'h00;
                rd_mux[PRK_HOLD_OFF_FLAG_BIT] = hold_off_flag_r;
                rd_mux[PRK_LONG_HOLD_FLAG_BIT] = long_hold_flag_r;
                rd_mux[PRK_KEY_PRESS_FLAG_BIT] = key_press_flag_r;
            end
            PRK_BUTTON_TIMING_ADDR: rd_mux = timing_r;
            PRK_FAULT_STATUS_ADDR: rd_mux = fault_r;
            PRK_RAIL_ENABLE_ADDR: rd_mux = enable_r;
            PRK_DISCHARGE_ADDR: rd_mux = discharge_en_r;
            PRK_IDENTITY_ADDR: rd_mux = {PART_CODE, REVISION};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end
endmodule

// ### dv/prk_ctrl_props.sv
// Purpose: port checker for the rail and power key block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: counters track button low time and powered-off time
`timescale 1ns/1ps
module prk_ctrl_props
    import prk_pkg::*;
#(
    parameter int TICK_CYCLES = 1,
    parameter logic [4:0] PART_CODE = 5'h00,
    parameter logic [2:0] REVISION = 3'h0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic power_button_n,
    input wire logic [7:0] rail_uvp,
    input wire logic [7:0] rail_run,
    input wire logic [7:0] rail_discharge,
    input wire logic power_up
);
    int low_cnt;
    int off_cnt;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt <= 0;
            off_cnt <= 0;
        end else begin
            low_cnt <= power_button_n ? 0 : low_cnt + 1;
            off_cnt <= power_up ? 0 : off_cnt + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_key_rd;
        reg_rd && reg_addr == PRK_KEY_STATUS_ADDR && power_button_n;
    endsequence
    sequence s_fault_rd;
        reg_rd && reg_addr == PRK_FAULT_STATUS_ADDR && !reg_wr;
    endsequence
    sequence s_uvp0;
        rail_uvp[0] [*4] ##0 !reg_wr;
    endsequence
    sequence s_clear;
        (rail_uvp == 8'h00) [*3] ##0
            (reg_wr && reg_addr == PRK_MISC_COMMAND_ADDR && reg_wdata[PRK_FAULT_CLEAR_BIT]);
    endsequence
    property p_run_off; !power_up ##1 !power_up |-> rail_run == 8'h00; endproperty
    property p_on_no_disch; rail_run != 8'h00 |-> rail_discharge == 8'h00; endproperty
    property p_buck_disch; $fell(power_up) |-> ##2 (rail_discharge[5:0] == 6'h3F) [*8]; endproperty
    property p_part; reg_rd && reg_addr == PRK_IDENTITY_ADDR |=> reg_rdata[7:3] == PART_CODE;
    endproperty
    property p_rev; reg_rd && reg_addr == PRK_IDENTITY_ADDR |=> reg_rdata[2:0] == REVISION;
    endproperty
    property p_fault_seen; s_uvp0 ##1 s_fault_rd |=> reg_rdata[0]; endproperty
    property p_fault_clear; s_clear ##2 (s_fault_rd and rail_uvp == 8'h00) |=> reg_rdata == 8'h00;
    endproperty
    property p_key_clear; power_button_n [*3] ##0 s_key_rd ##2 s_key_rd |=> !reg_rdata[4];
    endproperty
    property p_press_on; $rose(power_up) && !power_button_n |-> low_cnt > 128 * TICK_CYCLES;
    endproperty
    property p_restart_wait; $rose(power_up) && power_button_n |-> off_cnt >= 1000 * TICK_CYCLES;
    endproperty
    property p_off_by_hold; $fell(power_up) |-> low_cnt > 6000 * TICK_CYCLES; endproperty
    a_run_off: assert property (p_run_off) else $error("rail runs while off");
    a_on_no_disch: assert property (p_on_no_disch) else $error("discharge while on");
    a_buck_disch: assert property (p_buck_disch) else $error("bucks not discharged");
    a_part: assert property (p_part) else $error("part code wrong");
    a_rev: assert property (p_rev) else $error("revision wrong");
    a_fault_seen: assert property (p_fault_seen) else $error("fault flag missing");
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
    a_key_clear: assert property (p_key_clear) else $error("long hold flag kept");
    a_press_on: assert property (p_press_on) else $error("power on too early");
    a_restart_wait: assert property (p_restart_wait) else $error("restart too early");
    a_off_by_hold: assert property (p_off_by_hold) else $error("power off too early");
endmodule

bind prk_ctrl prk_ctrl_props #(.TICK_CYCLES(TICK_CYCLES), .PART_CODE(PART_CODE),
    .REVISION(REVISION)) prk_ctrl_props_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_button_n(power_button_n), .rail_uvp(rail_uvp),
    .rail_run(rail_run), .rail_discharge(rail_discharge), .power_up(power_up));

// ### dv/prk_key_model.sv
// Purpose: power button and rail sense model
// Assumes: button line has a pull-up
// Notes: released button reads high
`timescale 1ns/1ps
module prk_key_model (
    input wire logic sys_clk,
    input wire logic press,
    input wire logic [7:0] uvp_req,
    output logic power_button_n,
    output logic [7:0] rail_uvp
);
    assign power_button_n = !press;
    always_ff @(posedge sys_clk) begin
        rail_uvp <= uvp_req;
    end
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench for the rail and power key block
// Assumes: tick of one clock, so 1 ms is one cycle
// Notes: read data checked through an expectation queue
`timescale 1ns/1ps
module testbench
    import prk_pkg::*;
;
    localparam logic [4:0] PC = 5'h0C; // arbitrary value
    localparam logic [2:0] RV = 3'h2; // arbitrary value
    logic sys_clk = 0;
    logic rstn = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic press = 0;
    logic rd_seen = 0;
    logic [7:0] uvp_req = 8'h00;
    logic [7:0] reg_rdata, rail_uvp, rail_run, rail_discharge, v;
    logic power_button_n, power_up;
    logic [7:0] exp_q[$];
    int errors = 0;
    int comparisons = 0;
    int t;
    int deb[4] = '{128, 500, 1000, 1500};
    int lng[4] = '{1000, 2000, 3000, 4000};
    int off[4] = '{6000, 7000, 8000, 10000};

    initial forever #50 sys_clk = ~sys_clk;

    prk_key_model prk_key_model_inst (.sys_clk(sys_clk), .press(press), .uvp_req(uvp_req),
        .power_button_n(power_button_n), .rail_uvp(rail_uvp));
    prk_ctrl #(.TICK_CYCLES(1), .PART_CODE(PC), .REVISION(RV)) prk_ctrl_inst (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_button_n(power_button_n), .rail_uvp(rail_uvp), .rail_run(rail_run),
        .rail_discharge(rail_discharge), .power_up(power_up));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            errors++;
            $display("mismatch at %0t: delay %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d, input logic [7:0] e);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) exp_q.push_back(e);
        // strobes are one-cycle pulses, never left up across a wait
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        rstn <= 0;
        press <= 0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1;
    endtask
    task automatic wait_pu(input logic lvl, input int lim, inout int n);
        while (power_up !== lvl && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // read data lands one cycle after the strobe is taken
    always @(posedge sys_clk) begin
        if (rd_seen) chk8(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        errors++;
        print_verdict;
    end

    initial begin
        void'($urandom(36688));
        repeat (20) @(posedge sys_clk);
        rstn <= 1;
        acc(1, 0, PRK_IDENTITY_ADDR, 8'hFF, 8'h00);
        acc(1, 0, 8'h10, 8'h5A, 8'h00);
        acc(0, 1, PRK_BUTTON_TIMING_ADDR, 0, 8'hC7);
        acc(0, 1, PRK_RAIL_ENABLE_ADDR, 0, 8'hFF);
        acc(0, 1, PRK_DISCHARGE_ADDR, 0, 8'h00);
        acc(0, 1, PRK_FAULT_STATUS_ADDR, 0, 8'h00);
        acc(0, 1, PRK_IDENTITY_ADDR, 0, {PC, RV});
        acc(0, 1, 8'h10, 0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            acc(1, 0, PRK_RAIL_ENABLE_ADDR, v, 0);
            acc(1, 0, PRK_DISCHARGE_ADDR, ~v, 0);
            acc(0, 1, PRK_RAIL_ENABLE_ADDR, 0, v);
            acc(0, 1, PRK_DISCHARGE_ADDR, 0, ~v);
        end
        v = 8'($urandom) | 8'h01;
        uvp_req <= v;
        idle(5);
        acc(0, 1, PRK_FAULT_STATUS_ADDR, 0, v);
        uvp_req <= 8'h00;
        idle(6);
        acc(0, 1, PRK_FAULT_STATUS_ADDR, 0, v);
        acc(1, 0, PRK_MISC_COMMAND_ADDR, 8'h08, 0);
        acc(0, 1, PRK_FAULT_STATUS_ADDR, 0, 8'h00);
        acc(0, 1, PRK_MISC_COMMAND_ADDR, 0, 8'h00);
        // two short taps must not power on
        repeat (2) begin
            press <= 1;
            idle(100);
            press <= 0;
            idle(2);
        end
        chk8({7'h00, power_up}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            idle(1);
            do_reset;
            acc(1, 0, PRK_BUTTON_TIMING_ADDR, 8'(i * 20), 0);
            press <= 1;
            t = 0;
            wait_pu(1, 2000, t);
            chk_rng(t, deb[i] + 1, deb[i] + 6);
            idle(1);
            t += 1;
            chk8(rail_run, 8'hFF);
            acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h08);
            repeat (lng[i] - 4 - t) @(posedge sys_clk);
            acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h00);
            repeat (8) @(posedge sys_clk);
            acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h10);
            press <= 0;
            idle(4);
            acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h00);
            acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            idle(1);
            do_reset;
            acc(1, 0, PRK_BUTTON_TIMING_ADDR, {i != 1, i != 2, 4'h0, 2'(i)}, 0);
            acc(1, 0, PRK_DISCHARGE_ADDR, 8'hC0, 0);
            press <= 1;
            t = 0;
            wait_pu(1, 200, t);
            wait_pu(0, off[i] + 20, t);
            if (i == 2) begin
                chk8({7'h00, power_up}, 8'h01);
                press <= 0;
            end else begin
                chk_rng(t, off[i] + 1, off[i] + 8);
                idle(2);
                chk8(rail_discharge, 8'hFF);
                acc(0, 1, PRK_KEY_STATUS_ADDR, 0, 8'h58);
                press <= 0;
                t = 0;
                wait_pu(1, 1200, t);
                if (i == 1) chk8({7'h00, power_up}, 8'h00);
                else chk_rng(t, 1056, 1070);
                if (i == 1) chk8(rail_discharge, 8'hC0);
            end
        end
        idle(3);
        print_verdict;
    end
endmodule
